// file: design/uplc_pkg.sv
// constants and types shared by the usb port line control block
//
// Functional notes
// - two identical control registers, one per engine
// - bit 13 reads live port A D+ level
// - bit 12 reads live port A D- level
// - bit 10 selects low speed when set
// - bit 9 selects host role when set
// - device role serves only the selected port
// - resistor enable low disconnects every pull resistor
// - host role enables pull-downs on both lines
// - device role pulls D- if low, else D+
// - force field gives normal, SE0, J, K
// - forced state ignores the active-port choice
// - suspend bit powers down transceivers of both ports
// - suspended engine still detects a wakeup on lines
// - host frame-marker enable emits SOF or EOP keep-alive
// - register reachable from processor and parallel host port
package uplc_pkg;

  // register word addresses, one per serial engine
  localparam logic [15:0] CTRL_ENGINE1_ADDR = 16'hc08a;
  localparam logic [15:0] CTRL_ENGINE2_ADDR = 16'hc0aa;

  // field positions
  localparam int unsigned DP_STATUS_BIT  = 13;
  localparam int unsigned DM_STATUS_BIT  = 12;
  localparam int unsigned LOW_SPEED_BIT  = 10;
  localparam int unsigned HOST_ROLE_BIT  = 9;
  localparam int unsigned RES_ENABLE_BIT = 7;
  localparam int unsigned FORCE_LSB      = 3;
  localparam int unsigned SUSPEND_BIT    = 2;
  localparam int unsigned FRAME_EN_BIT   = 0;

  // writable bits: 10, 9, 7, 4, 3, 2, 0
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h069d;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED   = 16'h0000;

  // line forcing modes
  typedef enum logic [1:0] {
    UPLC_FORCE_NORMAL = 2'h0,
    UPLC_FORCE_SE0    = 2'h1,
    UPLC_FORCE_J      = 2'h2,
    UPLC_FORCE_K      = 2'h3
  } uplc_force_e;

  // frame marker period: 1 ms at a 100 ns clock
  localparam int unsigned FRAME_NS      = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FRAME_CYCLES  = FRAME_NS / CLK_PERIOD_NS;

endpackage

// file: design/uplc_engine.sv
// line drive, pull resistors, suspend, wakeup and frame markers of one engine
`timescale 1ns/100ps
module uplc_engine #(
  parameter int unsigned FRAME_CYCLES = uplc_pkg::FRAME_CYCLES  // cycles between markers
) (
  input  wire logic       i_clk,        // system clock
  input  wire logic       i_reset,      // synchronous reset, active high
  input  wire logic       i_low_speed,  // 1 low speed, 0 full speed
  input  wire logic       i_host,       // 1 host role, 0 device role
  input  wire logic       i_res_en,     // pull resistor enable
  input  wire logic [1:0] i_force,      // line forcing mode
  input  wire logic       i_suspend,    // suspend enable
  input  wire logic       i_frame_en,   // frame marker enable
  input  wire logic       i_port_sel,   // active-port choice, 0 selects port a
  input  wire logic       i_dp_sync,    // synchronised D+ level
  input  wire logic       i_dm_sync,    // synchronised D- level
  input  wire logic       i_sie_dp,     // engine drive value for D+
  input  wire logic       i_sie_dm,     // engine drive value for D-
  input  wire logic       i_sie_oe,     // engine drive enable
  output logic            o_dp,         // D+ output value
  output logic            o_dm,         // D- output value
  output logic            o_dp_oe,      // D+ output enable
  output logic            o_dm_oe,      // D- output enable
  output logic            o_pu_dp,      // pull-up on D+
  output logic            o_pu_dm,      // pull-up on D-
  output logic            o_pd_dp,      // pull-down on D+
  output logic            o_pd_dm,      // pull-down on D-
  output logic            o_xcvr_pd,    // transceiver power down, both ports
  output logic            o_sof_req,    // pulse: send start of frame
  output logic            o_eop_req,    // pulse: send low speed keep-alive
  output logic            o_wakeup      // pulse: line activity while suspended
);

  localparam int unsigned CW = $clog2(FRAME_CYCLES);

  typedef struct packed {
    logic          dp;
    logic          dm;
    logic          oe;
    logic          pu_dp;
    logic          pu_dm;
    logic          pd_dp;
    logic          pd_dm;
    logic          xcvr_pd;
    logic          sof;
    logic          eop;
    logic          wake;
    logic          wake_seen;
    logic          susp_d;
    logic          idle_dp;
    logic          idle_dm;
    logic [1:0]    settle;
    logic [CW-1:0] frame_cnt;
  } uplc_eng_s;

  uplc_eng_s st_r;
  uplc_eng_s st_nxt;
  logic      marker_on;

  // markers only run in host role on port a and never while powered down
  assign marker_on = i_host && i_frame_en && !i_port_sel && !i_suspend;

  // next state of the whole engine
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sof  = 1'b0;
    st_nxt.eop  = 1'b0;
    st_nxt.wake = 1'b0;

    // forced states override the port choice; normal follows the engine
    case (uplc_pkg::uplc_force_e'(i_force))
      uplc_pkg::UPLC_FORCE_SE0: begin
        st_nxt.dp = 1'b0;
        st_nxt.dm = 1'b0;
        st_nxt.oe = 1'b1;
      end
      uplc_pkg::UPLC_FORCE_J: begin
        st_nxt.dp = !i_low_speed;  // J idles D+ high at full speed
        st_nxt.dm = i_low_speed;
        st_nxt.oe = 1'b1;
      end
      uplc_pkg::UPLC_FORCE_K: begin
        st_nxt.dp = i_low_speed;
        st_nxt.dm = !i_low_speed;
        st_nxt.oe = 1'b1;
      end
      default: begin
        st_nxt.dp = i_sie_dp;
        st_nxt.dm = i_sie_dm;
        // only the selected port carries traffic; none while suspended
        st_nxt.oe = i_sie_oe && !i_port_sel && !i_suspend;
      end
    endcase

    // pull resistor table
    st_nxt.pd_dp = i_res_en && i_host;
    st_nxt.pd_dm = i_res_en && i_host;
    st_nxt.pu_dm = i_res_en && !i_host && i_low_speed;
    st_nxt.pu_dp = i_res_en && !i_host && !i_low_speed;

    st_nxt.xcvr_pd = i_suspend;
    st_nxt.susp_d  = i_suspend;

    // keep taking the idle snapshot until our own suspend line change has
    // passed the synchroniser, so entering suspend never looks like a wakeup
    if (!i_suspend) begin
      st_nxt.wake_seen = 1'b0;
      st_nxt.settle    = '0;
    end else if (!(&st_r.settle)) begin
      st_nxt.idle_dp = i_dp_sync;
      st_nxt.idle_dm = i_dm_sync;
      st_nxt.settle  = st_r.settle + {1'b0, st_r.susp_d};
    end else if (!st_r.wake_seen &&
                 (i_dp_sync != st_r.idle_dp || i_dm_sync != st_r.idle_dm)) begin
      st_nxt.wake      = 1'b1;
      st_nxt.wake_seen = 1'b1;
    end

    // frame marker period counter
    if (!marker_on) begin
      st_nxt.frame_cnt = '0;
    end else if (st_r.frame_cnt == CW'(FRAME_CYCLES - 1)) begin
      st_nxt.frame_cnt = '0;
      st_nxt.sof       = !i_low_speed;
      st_nxt.eop       = i_low_speed;
    end else begin
      st_nxt.frame_cnt = st_r.frame_cnt + CW'(1);
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_dp      = st_r.dp;
  assign o_dm      = st_r.dm;
  assign o_dp_oe   = st_r.oe;
  assign o_dm_oe   = st_r.oe;
  assign o_pu_dp   = st_r.pu_dp;
  assign o_pu_dm   = st_r.pu_dm;
  assign o_pd_dp   = st_r.pd_dp;
  assign o_pd_dm   = st_r.pd_dm;
  assign o_xcvr_pd = st_r.xcvr_pd;
  assign o_sof_req = st_r.sof;
  assign o_eop_req = st_r.eop;
  assign o_wakeup  = st_r.wake;

endmodule  // uplc_engine

// file: design/uplc_port_line_control.sv
// port control registers of both serial engines with their two access ports
`timescale 1ns/100ps
module uplc_port_line_control #(
  parameter int unsigned FRAME_CYCLES = uplc_pkg::FRAME_CYCLES  // cycles between markers
) (
  input  wire logic        i_clk,         // system clock, 10 MHz
  input  wire logic        i_reset,       // synchronous reset, active high
  // embedded processor access
  input  wire logic [15:0] i_cpu_addr,    // processor word address
  input  wire logic        i_cpu_wr,      // processor write strobe
  input  wire logic        i_cpu_rd,      // processor read strobe
  input  wire logic [15:0] i_cpu_wdata,   // processor write data
  output logic      [15:0] o_cpu_rdata,   // processor read data, next cycle
  // parallel host port access
  input  wire logic [15:0] i_hpi_addr,    // parallel host port word address
  input  wire logic        i_hpi_wr,      // parallel host port write strobe
  input  wire logic        i_hpi_rd,      // parallel host port read strobe
  input  wire logic [15:0] i_hpi_wdata,   // parallel host port write data
  output logic      [15:0] o_hpi_rdata,   // parallel host port read data
  // per engine, index 0 is engine 1
  input  wire logic [1:0]  i_port_sel,    // active-port choice, 0 selects port a
  input  wire logic [1:0]  i_sie_dp,      // engine drive value for D+
  input  wire logic [1:0]  i_sie_dm,      // engine drive value for D-
  input  wire logic [1:0]  i_sie_oe,      // engine drive enable
  input  wire logic [1:0]  i_dp,          // port a D+ pin level
  input  wire logic [1:0]  i_dm,          // port a D- pin level
  output logic      [1:0]  o_dp,          // port a D+ drive value
  output logic      [1:0]  o_dm,          // port a D- drive value
  output logic      [1:0]  o_dp_oe,       // port a D+ output enable
  output logic      [1:0]  o_dm_oe,       // port a D- output enable
  output logic      [1:0]  o_pu_dp,       // pull-up on D+
  output logic      [1:0]  o_pu_dm,       // pull-up on D-
  output logic      [1:0]  o_pd_dp,       // pull-down on D+
  output logic      [1:0]  o_pd_dm,       // pull-down on D-
  output logic      [1:0]  o_xcvr_pd,     // transceiver power down
  output logic      [1:0]  o_sof_req,     // start of frame request pulse
  output logic      [1:0]  o_eop_req,     // keep-alive request pulse
  output logic      [1:0]  o_wakeup       // wakeup detect pulse
);

  localparam int unsigned NENG = 2;

  typedef struct packed {
    logic [NENG-1:0][15:0] ctrl;
    logic [15:0]           cpu_rdata;
    logic [15:0]           hpi_rdata;
    logic [NENG-1:0]       dp_s1;
    logic [NENG-1:0]       dp_s2;
    logic [NENG-1:0]       dm_s1;
    logic [NENG-1:0]       dm_s2;
  } uplc_top_s;

  uplc_top_s st_r;
  uplc_top_s st_nxt;

  // address decode: returns hit flag and engine index
  function automatic logic [1:0] decode(input logic [15:0] addr);
    logic [1:0] res;
    res = 2'h0;
    if (addr == uplc_pkg::CTRL_ENGINE1_ADDR) begin
      res = 2'h2;
    end else if (addr == uplc_pkg::CTRL_ENGINE2_ADDR) begin
      res = 2'h3;
    end
    return res;
  endfunction

  // read image: writable fields plus live line levels, reserved reads zero
  function automatic logic [15:0] read_word(input logic [15:0] ctrl,
                                            input logic        dp,
                                            input logic        dm);
    logic [15:0] w;
    w = ctrl & uplc_pkg::CTRL_WRITE_MASK;
    w[uplc_pkg::DP_STATUS_BIT] = dp;
    w[uplc_pkg::DM_STATUS_BIT] = dm;
    return w;
  endfunction

  logic [1:0] cpu_dec;
  logic [1:0] hpi_dec;

  assign cpu_dec = decode(i_cpu_addr);
  assign hpi_dec = decode(i_hpi_addr);

  // next state: synchronisers, register writes, read data
  always_comb begin
    st_nxt       = st_r;
    // two flops per pin; only the second stage is read anywhere
    st_nxt.dp_s1 = i_dp;
    st_nxt.dp_s2 = st_r.dp_s1;
    st_nxt.dm_s1 = i_dm;
    st_nxt.dm_s2 = st_r.dm_s1;

    // host port write first so a same-cycle processor write wins
    if (i_hpi_wr && hpi_dec[1]) begin
      st_nxt.ctrl[hpi_dec[0]] = i_hpi_wdata & uplc_pkg::CTRL_WRITE_MASK;
    end
    if (i_cpu_wr && cpu_dec[1]) begin
      st_nxt.ctrl[cpu_dec[0]] = i_cpu_wdata & uplc_pkg::CTRL_WRITE_MASK;
    end

    // read data is held until the next read strobe
    if (i_cpu_rd) begin
      st_nxt.cpu_rdata = cpu_dec[1] ?
        read_word(st_r.ctrl[cpu_dec[0]], st_r.dp_s2[cpu_dec[0]], st_r.dm_s2[cpu_dec[0]]) :
        uplc_pkg::READ_UNMAPPED;
    end
    if (i_hpi_rd) begin
      st_nxt.hpi_rdata = hpi_dec[1] ?
        read_word(st_r.ctrl[hpi_dec[0]], st_r.dp_s2[hpi_dec[0]], st_r.dm_s2[hpi_dec[0]]) :
        uplc_pkg::READ_UNMAPPED;
    end
  end

  // state register; reset clears control fields and synchroniser flops, line status then follows the pins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r      <= '0;
      st_r.ctrl <= {NENG{uplc_pkg::CTRL_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_cpu_rdata = st_r.cpu_rdata;
  assign o_hpi_rdata = st_r.hpi_rdata;

  // one line controller per serial engine
  for (genvar g = 0; g < NENG; g++) begin : g_eng
    uplc_engine #(
      .FRAME_CYCLES (FRAME_CYCLES)
    ) u_eng (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_low_speed (st_r.ctrl[g][uplc_pkg::LOW_SPEED_BIT]),
      .i_host      (st_r.ctrl[g][uplc_pkg::HOST_ROLE_BIT]),
      .i_res_en    (st_r.ctrl[g][uplc_pkg::RES_ENABLE_BIT]),
      .i_force     (st_r.ctrl[g][uplc_pkg::FORCE_LSB +: 2]),
      .i_suspend   (st_r.ctrl[g][uplc_pkg::SUSPEND_BIT]),
      .i_frame_en  (st_r.ctrl[g][uplc_pkg::FRAME_EN_BIT]),
      .i_port_sel  (i_port_sel[g]),
      .i_dp_sync   (st_r.dp_s2[g]),
      .i_dm_sync   (st_r.dm_s2[g]),
      .i_sie_dp    (i_sie_dp[g]),
      .i_sie_dm    (i_sie_dm[g]),
      .i_sie_oe    (i_sie_oe[g]),
      .o_dp        (o_dp[g]),
      .o_dm        (o_dm[g]),
      .o_dp_oe     (o_dp_oe[g]),
      .o_dm_oe     (o_dm_oe[g]),
      .o_pu_dp     (o_pu_dp[g]),
      .o_pu_dm     (o_pu_dm[g]),
      .o_pd_dp     (o_pd_dp[g]),
      .o_pd_dm     (o_pd_dm[g]),
      .o_xcvr_pd   (o_xcvr_pd[g]),
      .o_sof_req   (o_sof_req[g]),
      .o_eop_req   (o_eop_req[g]),
      .o_wakeup    (o_wakeup[g])
    );
  end

endmodule  // uplc_port_line_control

// file: tb/uplc_line_asserts.sv
// assertion checker for the usb port line control registers and line outputs
`timescale 1ns/100ps
module uplc_line_asserts #(
  parameter int unsigned FRAME_CYCLES = 16  // cycles between markers
) (
  input wire logic        i_clk,        // system clock
  input wire logic        i_reset,      // synchronous reset
  input wire logic [15:0] i_cpu_addr,   // processor address
  input wire logic        i_cpu_wr,     // processor write
  input wire logic        i_cpu_rd,     // processor read
  input wire logic [15:0] i_cpu_wdata,  // processor write data
  input wire logic [15:0] o_cpu_rdata,  // processor read data
  input wire logic [15:0] i_hpi_addr,   // host port address
  input wire logic        i_hpi_wr,     // host port write
  input wire logic [1:0]  i_dp,         // D+ pin level
  input wire logic [1:0]  o_dp,         // D+ drive
  input wire logic [1:0]  o_dm,         // D- drive
  input wire logic [1:0]  o_dp_oe,      // D+ enable
  input wire logic [1:0]  o_dm_oe,      // D- enable
  input wire logic [1:0]  o_pu_dp,      // pull-up D+
  input wire logic [1:0]  o_pu_dm,      // pull-up D-
  input wire logic [1:0]  o_pd_dp,      // pull-down D+
  input wire logic [1:0]  o_pd_dm,      // pull-down D-
  input wire logic [1:0]  o_xcvr_pd,    // transceiver power down
  input wire logic [1:0]  o_sof_req,    // frame start pulse
  input wire logic [1:0]  o_eop_req,    // keep-alive pulse
  input wire logic [1:0]  o_wakeup      // wakeup pulse
);
  logic        hit, hhit, mark, seen_r;
  logic [15:0] w1_r, w2_r, gap_r;
  logic [2:0]  dp_h_r, rst_h_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // a lone write to engine 1 lets its effect be judged two edges later
  assign hit  = i_cpu_wr && i_cpu_addr == 16'hc08a;
  assign hhit = i_hpi_wr && i_hpi_addr == 16'hc08a;
  assign mark = o_sof_req[0] | o_eop_req[0];
  // history of write data, pin level and reset, plus the gap between markers
  always_ff @(posedge i_clk) begin
    w1_r    <= i_cpu_wdata;
    w2_r    <= w1_r;
    dp_h_r  <= {dp_h_r[1:0], i_dp[0]};
    rst_h_r <= {rst_h_r[1:0], i_reset};
    seen_r  <= i_reset ? 1'b0 : (seen_r | mark);
    gap_r   <= mark ? 16'h0001 : ((gap_r == 16'hffff) ? gap_r : gap_r + 16'h0001);
  end
  pull_down_a: assert property (hit ##1 !(hit || hhit) |=>
    o_pd_dp[0] == (w2_r[9] & w2_r[7]) && o_pd_dm[0] == (w2_r[9] & w2_r[7]))
    else $error("pull-down enables wrong after write");
  pull_up_a: assert property (hit ##1 !(hit || hhit) |=>
    o_pu_dp[0] == (w2_r[7] & !w2_r[9] & !w2_r[10]) && o_pu_dm[0] == (w2_r[7] & !w2_r[9] & w2_r[10]))
    else $error("pull-up enables wrong after write");
  force_se0_a: assert property (hit && i_cpu_wdata[4:3] == 2'h1 ##1 !(hit || hhit) |=>
    o_dp_oe[0] && o_dm_oe[0] && !o_dp[0] && !o_dm[0]) else $error("forced reset state wrong");
  force_jk_a: assert property (hit && i_cpu_wdata[4] ##1 !(hit || hhit) |=>
    o_dp_oe[0] && o_dm_oe[0] && o_dp[0] == !(w2_r[10] ^ w2_r[3]) && o_dm[0] == (w2_r[10] ^ w2_r[3]))
    else $error("forced J or K state wrong");
  suspend_pd_a: assert property (hit ##1 !(hit || hhit) |=> o_xcvr_pd[0] == w2_r[2])
    else $error("power down does not follow suspend");
  rsvd_zero_a: assert property (i_cpu_rd |=> (o_cpu_rdata & 16'hc962) == 16'h0000)
    else $error("reserved bits read nonzero");
  unmapped_zero_a: assert property (i_cpu_rd && i_cpu_addr != 16'hc08a &&
    i_cpu_addr != 16'hc0aa |=> o_cpu_rdata == 16'h0000) else $error("unmapped read nonzero");
  status_dp_a: assert property (i_cpu_rd && i_cpu_addr == 16'hc08a && rst_h_r == 3'h0 &&
    dp_h_r == {3{i_dp[0]}} |=> o_cpu_rdata[13] == $past(i_dp[0])) else $error("D+ status wrong");
  marker_gap_a: assert property (mark && seen_r |-> gap_r >= FRAME_CYCLES && !(o_sof_req[0] &&
    o_eop_req[0])) else $error("frame markers too close or doubled");
  wakeup_susp_a: assert property (o_wakeup[0] |-> $past(o_xcvr_pd[0]))
    else $error("wakeup outside suspend");
endmodule  // uplc_line_asserts

bind uplc_port_line_control uplc_line_asserts #(.FRAME_CYCLES(FRAME_CYCLES)) chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr),
  .i_cpu_rd(i_cpu_rd), .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata),
  .i_hpi_addr(i_hpi_addr), .i_hpi_wr(i_hpi_wr), .i_dp(i_dp), .o_dp(o_dp), .o_dm(o_dm),
  .o_dp_oe(o_dp_oe), .o_dm_oe(o_dm_oe), .o_pu_dp(o_pu_dp), .o_pu_dm(o_pu_dm),
  .o_pd_dp(o_pd_dp), .o_pd_dm(o_pd_dm), .o_xcvr_pd(o_xcvr_pd), .o_sof_req(o_sof_req),
  .o_eop_req(o_eop_req), .o_wakeup(o_wakeup));

// file: tb/uplc_usb_far_end.sv
// far-end model: a usb host port with line pull-downs that can signal resume
`timescale 1ns/100ps
module uplc_usb_far_end (
  input  wire logic i_dp,       // near end D+ value
  input  wire logic i_dm,       // near end D- value
  input  wire logic i_dp_oe,    // near end D+ enable
  input  wire logic i_dm_oe,    // near end D- enable
  input  wire logic i_pu_dp,    // near end pull-up D+
  input  wire logic i_pu_dm,    // near end pull-up D-
  input  wire logic i_resume,   // drive K for resume
  output logic      o_line_dp,  // resolved D+ level
  output logic      o_line_dm   // resolved D- level
);
  // undriven lines take the near pull-up level, else fall to the far pull-down level, never hold a stale value
  assign o_line_dp = i_resume ? 1'b0 : (i_dp_oe ? i_dp : i_pu_dp);
  assign o_line_dm = i_resume ? 1'b1 : (i_dm_oe ? i_dm : i_pu_dm);
endmodule  // uplc_usb_far_end

// file: tb/uplc_port_line_control_bench.sv
// self-checking bench for the usb port line control block
`timescale 1ns/100ps
module uplc_port_line_control_bench;
  logic        i_clk, i_reset, i_cpu_wr, i_cpu_rd, i_hpi_wr, i_hpi_rd;
  logic [15:0] i_cpu_addr, i_cpu_wdata, i_hpi_addr, i_hpi_wdata, o_cpu_rdata, o_hpi_rdata, d;
  logic [1:0]  i_port_sel, sie_dp, sie_dm, sie_oe, resume, o_dp, o_dm;
  wire [1:0]   ln_dp, ln_dm;
  logic [1:0]  o_dp_oe, o_dm_oe, o_pu_dp, o_pu_dm, o_pd_dp, o_pd_dm, o_xcvr_pd;
  logic [1:0]  o_sof_req, o_eop_req, o_wakeup;
  int          mismatches, num_checks, cycles, ns, ne;
  // port choice, written word, expected {pu_dp pu_dm pd_dp pd_dm pwrdn dp dm oe}
  logic [24:0] rows [14] = '{25'h0000003, 25'h0028033, 25'h0068033, 25'h0008083,
    25'h0048043, 25'h0060003, 25'h0000801, 25'h0001005, 25'h0041003, 25'h0041805,
    25'h000040a, 25'h0000c09, 25'h1000002, 25'h1000801};
  uplc_port_line_control #(.FRAME_CYCLES(16)) dut_u (.i_clk(i_clk), .i_reset(i_reset),
    .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr), .i_cpu_rd(i_cpu_rd),
    .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata), .i_hpi_addr(i_hpi_addr),
    .i_hpi_wr(i_hpi_wr), .i_hpi_rd(i_hpi_rd), .i_hpi_wdata(i_hpi_wdata),
    .o_hpi_rdata(o_hpi_rdata), .i_port_sel(i_port_sel), .i_sie_dp(sie_dp), .i_sie_dm(sie_dm),
    .i_sie_oe(sie_oe), .i_dp(ln_dp), .i_dm(ln_dm), .o_dp(o_dp), .o_dm(o_dm), .o_dp_oe(o_dp_oe),
    .o_dm_oe(o_dm_oe), .o_pu_dp(o_pu_dp), .o_pu_dm(o_pu_dm), .o_pd_dp(o_pd_dp),
    .o_pd_dm(o_pd_dm), .o_xcvr_pd(o_xcvr_pd), .o_sof_req(o_sof_req), .o_eop_req(o_eop_req),
    .o_wakeup(o_wakeup));
  uplc_usb_far_end far_u [1:0] (.i_dp(o_dp), .i_dm(o_dm), .i_dp_oe(o_dp_oe), .i_dm_oe(o_dm_oe),
    .i_pu_dp(o_pu_dp), .i_pu_dm(o_pu_dm), .i_resume(resume), .o_line_dp(ln_dp), .o_line_dm(ln_dm));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // a hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one-cycle strobe on either access port; the next call leaves an idle cycle
  task automatic wr(input logic parallel_host_port, input logic [15:0] a, input logic [15:0] v);
    @(negedge i_clk);
    if (parallel_host_port) {i_hpi_wr, i_hpi_addr, i_hpi_wdata} = {1'b1, a, v};
    else {i_cpu_wr, i_cpu_addr, i_cpu_wdata} = {1'b1, a, v};
    @(negedge i_clk);
    {i_cpu_wr, i_hpi_wr} = 2'b00;
  endtask
  task automatic rd(input logic parallel_host_port, input logic [15:0] a);
    @(negedge i_clk);
    if (parallel_host_port) {i_hpi_rd, i_hpi_addr} = {1'b1, a};
    else {i_cpu_rd, i_cpu_addr} = {1'b1, a};
    @(negedge i_clk);
    {i_cpu_rd, i_hpi_rd} = 2'b00;
    d = parallel_host_port ? o_hpi_rdata : o_cpu_rdata;
  endtask
  task automatic markers(input logic ps, input logic [15:0] w, input int es, input int ee);
    wr(0, 16'hc08a, 16'h0000);
    i_port_sel[0] = ps;
    wr(0, 16'hc08a, w);  // frame-marker enable only ever set with host role
    ns = 0;
    ne = 0;
    repeat (44) begin
      @(negedge i_clk);
      ns += (o_sof_req[0] === 1'b1);
      ne += (o_eop_req[0] === 1'b1);
    end
    chk({ns[7:0], ne[7:0]}, {es[7:0], ee[7:0]}, "marker counts");
  endtask
  initial begin
    {i_cpu_wr, i_cpu_rd, i_hpi_wr, i_hpi_rd, i_cpu_addr, i_hpi_addr} = '0;
    {i_cpu_wdata, i_hpi_wdata, i_port_sel, resume, sie_dp} = '0;
    {sie_dm, sie_oe} = 4'hf;
    i_reset = 1'b1;
    repeat (10) @(negedge i_clk);
    i_reset = 1'b0;
    for (int i = 0; i < 14; i++) begin
      i_port_sel[0] = rows[i][24];
      wr(i[0], 16'hc08a, rows[i][23:8]);
      repeat (3) @(negedge i_clk);
      chk({8'h00, o_pu_dp[0], o_pu_dm[0], o_pd_dp[0], o_pd_dm[0], o_xcvr_pd[0], o_dp[0], o_dm[0],
        o_dp_oe[0] & o_dm_oe[0]}, {8'h00, rows[i][7:0]}, "line outputs");
      rd(~i[0], 16'hc08a);
      chk(d, (rows[i][23:8] & 16'h069d) | {2'h0, ln_dp[0], ln_dm[0], 12'h000}, "read back");
    end
    // engine 2 is separate from engine 1, on its own address
    wr(1, 16'hc0aa, 16'h0280);
    repeat (4) @(negedge i_clk);
    chk({12'h0, o_pd_dp, o_pd_dm}, 16'h000a, "engine pulls");
    rd(0, 16'hc0aa);
    chk(d, {2'h0, ln_dp[1], ln_dm[1], 12'h280}, "engine 2 read");
    wr(0, 16'hc08c, 16'hffff);
    rd(1, 16'hc08c);
    chk(d, 16'h0000, "unmapped read");
    // both ports write in one cycle: the processor's word is kept
    @(negedge i_clk);
    {i_cpu_wr, i_cpu_addr, i_cpu_wdata} = {1'b1, 16'hc08a, 16'h0080};
    {i_hpi_wr, i_hpi_addr, i_hpi_wdata} = {1'b1, 16'hc08a, 16'h0480};
    // both strobes drop after one edge so the host port word is not retaken alone
    @(negedge i_clk);
    {i_cpu_wr, i_hpi_wr} = 2'b00;
    rd(1, 16'hc08a);
    chk(d & 16'h0fff, 16'h0080, "write collision");
    markers(0, 16'h0201, 2, 0);
    markers(0, 16'h0601, 0, 2);
    markers(0, 16'h0200, 0, 0);
    markers(1, 16'h0201, 0, 0);
    i_port_sel[0] = 1'b0;
    wr(0, 16'hc08a, 16'h0084);
    repeat (6) @(negedge i_clk);
    resume[0] = 1'b1;
    ns = 0;
    repeat (8) begin
      @(negedge i_clk);
      ns += (o_wakeup[0] === 1'b1);
    end
    chk(16'(ns), 16'h0001, "wakeup pulses");
    resume[0] = 1'b0;
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    rd(0, 16'hc08a);
    chk(d & 16'h0fff, 16'h0000, "reset value");
    chk({8'h0, o_pu_dp, o_pu_dm, o_pd_dp, o_pd_dm}, 16'h0000, "pulls after reset");
    report_and_stop();
  end
endmodule  // uplc_port_line_control_bench
